// file: rtl/pusc_pkg.sv
package pusc_pkg;

  // ****************************************
  // command codes and register layout
  // ****************************************
  localparam logic [7:0] PUSC_CMD_USER_CFG = 8'hD1;
  localparam logic [7:0] PUSC_CMD_SHARE_CFG = 8'hD2;
  localparam logic [15:0] PUSC_USER_RST = 16'h2011;
  localparam logic [15:0] PUSC_SHARE_RST = 16'h0000;
  // writable bits; writes zero transmit bits 7, 4, 3 and reserved bits; reset sets bit 4
  localparam logic [15:0] PUSC_USER_WMASK = 16'hEB67;
  localparam logic [15:0] PUSC_SHARE_WMASK = 16'h1FFD;

  localparam int PUSC_U_MINDUTY_LSB = 14;
  localparam int PUSC_U_MINDUTY_EN = 13;
  localparam int PUSC_U_SYNC_TMO = 11;
  localparam int PUSC_U_FF_OFF = 9;
  localparam int PUSC_U_FSPREAD = 8;
  localparam int PUSC_U_TX_RATE = 7;
  localparam int PUSC_U_SYNC_UTIL = 6;
  localparam int PUSC_U_SYNC_OUT = 5;
  localparam int PUSC_U_TX_INH = 4;
  localparam int PUSC_U_TMO_INH = 3;
  localparam int PUSC_U_LS_ON = 2;
  localparam int PUSC_U_STBY_LSB = 0;
  localparam int PUSC_S_ID_LSB = 8;
  localparam int PUSC_S_MEMBERS_LSB = 5;
  localparam int PUSC_S_POS_LSB = 2;
  localparam int PUSC_S_EN = 0;

  localparam logic [1:0] PUSC_STBY_LOWPWR = 2'h0;
  localparam logic [1:0] PUSC_STBY_CONT = 2'h1;
  localparam logic [1:0] PUSC_STBY_RSVD = 2'h2;
  localparam logic [1:0] PUSC_STBY_PULSED = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam longint PUSC_CLK_HZ = 200_000_000;
  localparam longint PUSC_SYNC_OFF_MS = 500;
  localparam longint PUSC_SYNC_OFF_CYC = PUSC_SYNC_OFF_MS * PUSC_CLK_HZ / 1000;
  localparam int PUSC_SYNC_OFF_CW = 27;
  localparam logic [7:0] PUSC_EXT_CLK_WIN_CYC = 8'hFF;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {PUSC_SO_RUN, PUSC_SO_WAIT, PUSC_SO_OFF} pusc_sync_off_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } pusc_cmd_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } pusc_rsp_t;

  typedef struct packed {
    logic min_duty_en;
    logic [2:0] min_duty_num;
    logic ff_correct_en;
    logic use_ext_clk;
    logic low_side_on;
    logic low_power;
    logic monitor_cont;
    logic monitor_pulsed;
    logic telemetry_avail;
  } pusc_ctrl_t;

  typedef struct packed {
    logic member;
    logic [4:0] rail_id;
    logic [2:0] members_m1;
    logic [2:0] position;
    logic id_mismatch;
  } pusc_share_t;

endpackage : pusc_pkg

// file: rtl/pusc_sync2.sv
`timescale 1ns/100ps
module pusc_sync2 import pusc_pkg::*; #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pusc_sync_state_t;

  pusc_sync_state_t st_reg;
  pusc_sync_state_t st_next;

  // first stage feeds only the second stage
  always_comb begin
    st_next.s1 = i_async;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.s2;

endmodule : pusc_sync2

// file: rtl/pusc_sync_timeout.sv
`timescale 1ns/100ps
module pusc_sync_timeout import pusc_pkg::*; #(
  parameter int CW = PUSC_SYNC_OFF_CW,
  parameter logic [CW-1:0] CYCLES = CW'(PUSC_SYNC_OFF_CYC)
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enabled,
  input wire logic i_tmo_en,
  output logic o_drive_allow
);

  typedef struct packed {
    pusc_sync_off_t state;
    logic [CW-1:0] cnt;
  } pusc_tmo_state_t;

  pusc_tmo_state_t st_reg;
  pusc_tmo_state_t st_next;

  // ****************************************
  // disable timeout of the switch clock
  // ****************************************
  always_comb begin
    st_next = st_reg;
    case (st_reg.state)
      PUSC_SO_RUN: begin
        st_next.cnt = '0;
        if (!i_enabled && i_tmo_en) begin
          st_next.state = PUSC_SO_WAIT;
        end
      end
      PUSC_SO_WAIT: begin
        if (i_enabled || !i_tmo_en) begin
          st_next.state = PUSC_SO_RUN;
        end else if (st_reg.cnt == CYCLES - CW'(1)) begin
          st_next.state = PUSC_SO_OFF;
        end else begin
          st_next.cnt = st_reg.cnt + CW'(1);
        end
      end
      PUSC_SO_OFF: begin
        if (i_enabled || !i_tmo_en) begin
          st_next.state = PUSC_SO_RUN;
        end
      end
      default: begin
        st_next.state = PUSC_SO_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_reg <= '{state: PUSC_SO_RUN, cnt: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_drive_allow = (st_reg.state != PUSC_SO_OFF);

  chk_off_after_delay: assert property (@(posedge i_clock) disable iff (i_rst)
    (st_reg.state == PUSC_SO_WAIT && st_next.state == PUSC_SO_OFF)
      |-> st_reg.cnt == CYCLES - CW'(1))
    else $error("switch clock stopped at wrong count");

  chk_off_only_disabled: assert property (@(posedge i_clock) disable iff (i_rst)
    !o_drive_allow |-> $past(!i_enabled) && $past(i_tmo_en))
    else $error("switch clock stopped while enabled or timeout off");

endmodule : pusc_sync_timeout

// file: rtl/pusc_config.sv
`timescale 1ns/100ps
// Summary of operation
// - ramp minimum duty is (N+1)/256 from bits 15:14, only when bit 13 set.
// - timeout bit set stops switch-clock output 500 ms after disable.
// - feed-forward bit clear corrects loop coefficients for supply; set disables it.
// - spreading clear ignores foreign faults unless sequencing, then sequence down outward.
// - spreading set shuts down at once on a fault from the fault group.
// - utilization clear auto-configures clock from pin; set uses external clock input.
// - output bit set drives internal switch clock onto the pin unless utilization is set; clear is input.
// - the three bus-transmit bits are zeroed on every write; reset sets bit 4.
// - while disabled, low-side drive follows the low-side control bit.
// - standby 00 while disabled enters low power, no telemetry.
// - standby 01 monitors continuously; 11 pulsed, telemetry on read; 10 reserved.
// - user feature register resets to 2011h.
// - share register upper byte holds the rail link ID 0 to 31.
// - bits 4:2 give this device's position within its share rail.
// - share control bit 0 at 1 makes the device a rail member, 0 standalone.
// - share register resets to 0000h, single-phase, no share rail.
// - the link ID identifies the rail; share members use the share register ID and flag a mismatch with the link ID.
module pusc_config import pusc_pkg::*; #(
  parameter int SYNC_OFF_CW = PUSC_SYNC_OFF_CW,
  parameter logic [SYNC_OFF_CW-1:0] SYNC_OFF_CYCLES = SYNC_OFF_CW'(PUSC_SYNC_OFF_CYC)
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire pusc_cmd_t i_cmd,
  output pusc_rsp_t o_rsp,
  input wire logic i_enable,
  input wire logic i_seq_en,
  input wire logic i_fault_rx,
  input wire logic i_fault_in_group,
  input wire logic [4:0] i_link_id,
  input wire logic i_telem_read,
  input wire logic i_int_sw_clk,
  input wire logic i_sync_i,
  output logic o_sync_o,
  output logic o_sync_oe,
  output logic o_sw_clk,
  output pusc_ctrl_t o_ctrl,
  output pusc_share_t o_share,
  output logic o_shutdown_now,
  output logic o_seq_down_req,
  output logic o_telem_sample
);

  typedef struct packed {
    logic [15:0] user;
    logic [15:0] share;
    pusc_rsp_t rsp;
    logic sync_prev;
    logic [7:0] ext_win;
    pusc_ctrl_t ctrl;
    pusc_share_t shr;
    logic sync_o;
    logic sync_oe;
    logic sw_clk;
    logic shutdown;
    logic seq_down;
    logic telem_sample;
  } pusc_cfg_state_t;

  pusc_cfg_state_t st_reg;
  pusc_cfg_state_t st_next;
  logic sync_in;
  logic sync_allow;

  // ****************************************
  // pin synchroniser and clock timeout
  // ****************************************
  pusc_sync2 #(
    .W(1)
  ) u_sync_pin (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_sync_i),
    .o_sync(sync_in)
  );

  pusc_sync_timeout #(
    .CW(SYNC_OFF_CW),
    .CYCLES(SYNC_OFF_CYCLES)
  ) u_sync_tmo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enabled(i_enable),
    .i_tmo_en(st_reg.user[PUSC_U_SYNC_TMO]),
    .o_drive_allow(sync_allow)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [1:0] stby;
    logic ext_present;
    logic use_ext;
    stby = st_reg.user[PUSC_U_STBY_LSB +: 2];
    ext_present = 1'b0;
    use_ext = 1'b0;
    st_next = st_reg;
    st_next.rsp.ack = 1'b0;
    st_next.rsp.err = 1'b0;

    // command port; masks zero reserved and transmit bits on every write
    if (i_cmd.valid) begin
      st_next.rsp.ack = 1'b1;
      case (i_cmd.code)
        PUSC_CMD_USER_CFG: begin
          if (i_cmd.write) begin
            st_next.user = i_cmd.wdata & PUSC_USER_WMASK;
          end else begin
            st_next.rsp.rdata = st_reg.user;
          end
        end
        PUSC_CMD_SHARE_CFG: begin
          if (i_cmd.write) begin
            st_next.share = i_cmd.wdata & PUSC_SHARE_WMASK;
          end else begin
            st_next.rsp.rdata = st_reg.share;
          end
        end
        default: begin
          st_next.rsp.err = 1'b1;
          st_next.rsp.rdata = 16'h0000;
        end
      endcase
    end

    // external clock seen recently on the pin; window avoids a stuck pin counting
    st_next.sync_prev = sync_in;
    if (sync_in && !st_reg.sync_prev) begin
      st_next.ext_win = PUSC_EXT_CLK_WIN_CYC;
    end else if (st_reg.ext_win != 8'h00) begin
      st_next.ext_win = st_reg.ext_win - 8'h01;
    end
    ext_present = (st_reg.ext_win != 8'h00);

    // clock source: forced external, or auto from pin activity
    if (st_reg.user[PUSC_U_SYNC_UTIL]) begin
      use_ext = 1'b1;
    end else begin
      use_ext = ext_present && !st_reg.user[PUSC_U_SYNC_OUT];
    end
    st_next.sw_clk = use_ext ? sync_in : i_int_sw_clk;
    st_next.sync_o = i_int_sw_clk;
    st_next.sync_oe = st_reg.user[PUSC_U_SYNC_OUT] && !use_ext && sync_allow;

    // loop and ramp controls
    st_next.ctrl.min_duty_en = st_reg.user[PUSC_U_MINDUTY_EN];
    st_next.ctrl.min_duty_num = {1'b0, st_reg.user[PUSC_U_MINDUTY_LSB +: 2]} + 3'h1;
    st_next.ctrl.ff_correct_en = !st_reg.user[PUSC_U_FF_OFF];
    st_next.ctrl.use_ext_clk = use_ext;
    st_next.ctrl.low_side_on = !i_enable && st_reg.user[PUSC_U_LS_ON];

    // standby; reserved code treated as low power
    st_next.ctrl.low_power = !i_enable &&
      (stby == PUSC_STBY_LOWPWR || stby == PUSC_STBY_RSVD);
    st_next.ctrl.monitor_cont = !i_enable && stby == PUSC_STBY_CONT;
    st_next.ctrl.monitor_pulsed = !i_enable && stby == PUSC_STBY_PULSED;
    st_next.ctrl.telemetry_avail = i_enable || stby == PUSC_STBY_CONT;
    st_next.telem_sample = i_telem_read &&
      (i_enable || stby == PUSC_STBY_CONT || stby == PUSC_STBY_PULSED);

    // fault spreading over the inter-device link
    st_next.shutdown = i_fault_rx && i_fault_in_group && st_reg.user[PUSC_U_FSPREAD];
    st_next.seq_down = i_fault_rx && !st_reg.user[PUSC_U_FSPREAD] && i_seq_en;

    // current-share placement; standalone uses the link ID
    st_next.shr.member = st_reg.share[PUSC_S_EN];
    st_next.shr.rail_id = st_reg.share[PUSC_S_EN] ?
      st_reg.share[PUSC_S_ID_LSB +: 5] : i_link_id;
    st_next.shr.members_m1 = st_reg.share[PUSC_S_MEMBERS_LSB +: 3];
    st_next.shr.position = st_reg.share[PUSC_S_POS_LSB +: 3];
    st_next.shr.id_mismatch = st_reg.share[PUSC_S_EN] &&
      (st_reg.share[PUSC_S_ID_LSB +: 5] != i_link_id);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.user <= PUSC_USER_RST;
      st_reg.share <= PUSC_SHARE_RST;
      st_reg.ctrl.min_duty_num <= 3'h1;
      st_reg.ctrl.ff_correct_en <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rsp = st_reg.rsp;
  assign o_ctrl = st_reg.ctrl;
  assign o_share = st_reg.shr;
  assign o_sync_o = st_reg.sync_o;
  assign o_sync_oe = st_reg.sync_oe;
  assign o_sw_clk = st_reg.sw_clk;
  assign o_shutdown_now = st_reg.shutdown;
  assign o_seq_down_req = st_reg.seq_down;
  assign o_telem_sample = st_reg.telem_sample;

  // ****************************************
  // checks
  // ****************************************
  chk_user_reset_val: assert property (@(posedge i_clock)
    $past(i_rst) |-> st_reg.user == 16'h2011)
    else $error("user register reset value wrong");

  chk_share_reset_val: assert property (@(posedge i_clock)
    $past(i_rst) |-> st_reg.share == 16'h0000 && !o_share.member)
    else $error("share register reset value wrong");

  chk_tx_bits_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_cmd.valid && i_cmd.write && i_cmd.code == PUSC_CMD_USER_CFG)
      |=> st_reg.user[7] == 1'b0 && st_reg.user[4:3] == 2'b00 &&
          st_reg.user[13] == $past(i_cmd.wdata[13]))
    else $error("transmit bits not held at zero");

  chk_rsvd_read_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_cmd.valid && !i_cmd.write && i_cmd.code == PUSC_CMD_SHARE_CFG)
      |=> o_rsp.ack && o_rsp.rdata[15:13] == 3'b000 && o_rsp.rdata[1] == 1'b0)
    else $error("reserved share bits read non-zero");

  chk_min_duty_num: assert property (@(posedge i_clock) disable iff (i_rst)
    !$past(i_rst)
      |-> o_ctrl.min_duty_num == {1'b0, $past(st_reg.user[15:14])} + 3'h1 &&
          o_ctrl.min_duty_en == $past(st_reg.user[13]))
    else $error("minimum duty output wrong");

  chk_ff_correct: assert property (@(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |-> o_ctrl.ff_correct_en == !$past(st_reg.user[9]))
    else $error("feed-forward correction wrong");

  chk_shutdown_now: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_fault_rx && i_fault_in_group && st_reg.user[8]) |=> o_shutdown_now && !o_seq_down_req)
    else $error("group fault did not shut down");

  chk_fault_ignored: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_fault_rx && !st_reg.user[8]) |=> !o_shutdown_now && o_seq_down_req == $past(i_seq_en))
    else $error("foreign fault handled wrongly");

  chk_low_side_off: assert property (@(posedge i_clock) disable iff (i_rst)
    o_ctrl.low_side_on |-> $past(!i_enable) && $past(st_reg.user[2]))
    else $error("low-side drive on without cause");

  chk_low_power: assert property (@(posedge i_clock) disable iff (i_rst)
    o_ctrl.low_power |-> $past(!i_enable) && !o_ctrl.telemetry_avail && !o_ctrl.monitor_cont)
    else $error("low power mode with telemetry");

  chk_pulsed_read: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_telem_read && !i_enable && st_reg.user[1:0] == PUSC_STBY_PULSED) |=> o_telem_sample)
    else $error("pulsed monitor missed read");

  chk_sync_drive: assert property (@(posedge i_clock) disable iff (i_rst)
    o_sync_oe |-> $past(st_reg.user[5]) && $past(!st_reg.user[6]))
    else $error("sync pin driven while input only");

  chk_share_member: assert property (@(posedge i_clock) disable iff (i_rst)
    !$past(i_rst)
      |-> o_share.member == $past(st_reg.share[0]) &&
          o_share.position == $past(st_reg.share[4:2]))
    else $error("share membership wrong");

  chk_shutdown_cause: assert property (@(posedge i_clock) disable iff (i_rst)
    o_shutdown_now |-> $past(i_fault_rx && i_fault_in_group && st_reg.user[8]))
    else $error("shutdown without group fault");

  chk_seq_down_cause: assert property (@(posedge i_clock) disable iff (i_rst)
    o_seq_down_req |-> $past(i_fault_rx && !st_reg.user[8] && i_seq_en))
    else $error("sequence down without cause");

  chk_ext_forced: assert property (@(posedge i_clock) disable iff (i_rst)
    (!$past(i_rst) && $past(st_reg.user[6])) |-> o_ctrl.use_ext_clk)
    else $error("forced external clock not used");

  chk_sync_oe_on: assert property (@(posedge i_clock) disable iff (i_rst)
    (!$past(i_rst) && $past(st_reg.user[5] && !st_reg.user[6] && sync_allow)) |-> o_sync_oe)
    else $error("sync pin not driven");

  chk_low_side_on: assert property (@(posedge i_clock) disable iff (i_rst)
    (!$past(i_rst) && $past(!i_enable && st_reg.user[2])) |-> o_ctrl.low_side_on)
    else $error("low-side drive not on while disabled");

  chk_no_telem_lowpwr: assert property (@(posedge i_clock) disable iff (i_rst)
    o_telem_sample |-> $past(i_telem_read) && $past(i_enable || st_reg.user[0]))
    else $error("telemetry sampled in low power");

  chk_cont_monitor: assert property (@(posedge i_clock) disable iff (i_rst)
    (!$past(i_rst) && $past(!i_enable && st_reg.user[1:0] == PUSC_STBY_CONT))
      |-> o_ctrl.monitor_cont && o_ctrl.telemetry_avail)
    else $error("continuous monitor not active");

  chk_rail_id_share: assert property (@(posedge i_clock) disable iff (i_rst)
    (!$past(i_rst) && $past(st_reg.share[0]))
      |-> o_share.rail_id == $past(st_reg.share[12:8]))
    else $error("member rail id not from share register");

  chk_rail_id_link: assert property (@(posedge i_clock) disable iff (i_rst)
    (!$past(i_rst) && !$past(st_reg.share[0]))
      |-> o_share.rail_id == $past(i_link_id) && !o_share.id_mismatch)
    else $error("standalone rail id not from link id");

endmodule : pusc_config

// file: sim/pusc_host_model.sv
`timescale 1ns/100ps
module pusc_host_model import pusc_pkg::*; (
  input wire logic i_clock,
  output pusc_cmd_t o_cmd,
  input wire pusc_rsp_t i_rsp
);
  // ****************************************
  // host side of the command port
  // ****************************************
  initial begin
    o_cmd = '0;
  end

  // caller enters just after a rising edge; the answer is taken one edge later
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] rd, output logic ack, output logic err);
    o_cmd.valid = 1'b1;
    o_cmd.write = w;
    o_cmd.code = c;
    o_cmd.wdata = d;
    @(posedge i_clock);
    #1;
    rd = i_rsp.rdata;
    ack = i_rsp.ack;
    err = i_rsp.err;
    // idle bus shows inverted leftovers, not a helpful stale value
    o_cmd.valid = 1'b0;
    o_cmd.code = ~c;
    o_cmd.wdata = ~d;
    // one idle edge so a following call never raises valid in the same step
    @(posedge i_clock);
    #1;
  endtask : xfer

  // host packs the share id it is given and counts members minus one
  function automatic logic [15:0] share_word(input logic [4:0] id, input logic [3:0] size,
                                             input logic [2:0] pos, input logic member);
    logic [2:0] m1;
    m1 = 3'(size - 4'h1);
    return {3'h0, id, m1, pos, 1'b0, member};
  endfunction : share_word
endmodule : pusc_host_model

// file: sim/power_user_and_share_config_test.sv
`timescale 1ns/100ps
module power_user_and_share_config_test import pusc_pkg::*;;
  logic clock, rst, enable, seq_en, fault_rx, in_group, telem_read, int_sw_clk, sync_i;
  logic [4:0] link_id;
  logic sync_o, sync_oe, sw_clk, shutdown_now, seq_down_req, telem_sample;
  pusc_cmd_t cmd;
  pusc_rsp_t rsp;
  pusc_ctrl_t ctrl;
  pusc_share_t share;
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  pusc_host_model host (.i_clock(clock), .o_cmd(cmd), .i_rsp(rsp));

  pusc_config #(.SYNC_OFF_CW(27), .SYNC_OFF_CYCLES(27'd20)) dut (
    .i_clock(clock), .i_rst(rst), .i_cmd(cmd), .o_rsp(rsp), .i_enable(enable),
    .i_seq_en(seq_en), .i_fault_rx(fault_rx), .i_fault_in_group(in_group),
    .i_link_id(link_id), .i_telem_read(telem_read), .i_int_sw_clk(int_sw_clk),
    .i_sync_i(sync_i), .o_sync_o(sync_o), .o_sync_oe(sync_oe), .o_sw_clk(sw_clk),
    .o_ctrl(ctrl), .o_share(share), .o_shutdown_now(shutdown_now),
    .o_seq_down_req(seq_down_req), .o_telem_sample(telem_sample)
  );

  // ****************************************
  // clock, internal switch clock, hang guard
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always begin
    @(posedge clock);
    #1;
    int_sw_clk <= ~int_sw_clk;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      errors++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // register value reaches the outputs one cycle after the write edge
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    logic [15:0] rd;
    logic ack, err;
    host.xfer(1'b1, code, data, rd, ack, err);
    chk("write ack", 16'h0001, 16'(ack));
    cyc(1);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] code, input logic [15:0] exp,
                        input logic exp_err);
    logic [15:0] rd;
    logic ack, err;
    host.xfer(1'b0, code, 16'h0000, rd, ack, err);
    chk("read ack", 16'h0001, 16'(ack));
    chk("read err", 16'(exp_err), 16'(err));
    chk(what, exp, rd);
  endtask : rd_chk

  task automatic fault(input logic grp, input logic seq, input logic sd, input logic dn);
    in_group = grp;
    seq_en = seq;
    fault_rx = 1'b1;
    cyc(1);
    fault_rx = 1'b0;
    chk("shutdown_now", 16'(sd), 16'(shutdown_now));
    chk("seq_down_req", 16'(dn), 16'(seq_down_req));
    cyc(1);
  endtask : fault

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk("user after reset", PUSC_CMD_USER_CFG, 16'h2011, 1'b0);
    rd_chk("share after reset", PUSC_CMD_SHARE_CFG, 16'h0000, 1'b0);
    chk("min_duty_num", 16'h0001, 16'(ctrl.min_duty_num));
    chk("ff_correct_en", 16'h0001, 16'(ctrl.ff_correct_en));
    chk("member", 16'h0000, 16'(share.member));
    rd_chk("unknown code", 8'hD3, 16'h0000, 1'b1);
  endtask : t_reset

  task automatic t_masks();
    wr(PUSC_CMD_USER_CFG, 16'hFFFF);
    rd_chk("user masked", PUSC_CMD_USER_CFG, 16'hEB67, 1'b0);
    wr(PUSC_CMD_SHARE_CFG, 16'hFFFF);
    rd_chk("share masked", PUSC_CMD_SHARE_CFG, 16'h1FFD, 1'b0);
    chk("rail_id max", 16'h001F, 16'(share.rail_id));
  endtask : t_masks

  task automatic t_loop_cfg();
    for (int n = 0; n < 4; n++) begin
      wr(PUSC_CMD_USER_CFG, {2'(n), 1'b1, 13'h0000});
      chk("min_duty_num", 16'(n + 1), 16'(ctrl.min_duty_num));
      chk("min_duty_en", 16'h0001, 16'(ctrl.min_duty_en));
    end
    wr(PUSC_CMD_USER_CFG, 16'hC000);
    chk("min_duty_en off", 16'h0000, 16'(ctrl.min_duty_en));
    chk("ff on", 16'h0001, 16'(ctrl.ff_correct_en));
    wr(PUSC_CMD_USER_CFG, 16'h0200);
    chk("ff off", 16'h0000, 16'(ctrl.ff_correct_en));
  endtask : t_loop_cfg

  task automatic t_fault();
    wr(PUSC_CMD_USER_CFG, 16'h0100);
    fault(1'b1, 1'b0, 1'b1, 1'b0);
    fault(1'b1, 1'b1, 1'b1, 1'b0);
    fault(1'b0, 1'b0, 1'b0, 1'b0);
    wr(PUSC_CMD_USER_CFG, 16'h0000);
    fault(1'b1, 1'b1, 1'b0, 1'b1);
    fault(1'b1, 1'b0, 1'b0, 1'b0);
  endtask : t_fault

  task automatic t_standby();
    // {low_power, cont, pulsed, avail, sample}; reserved code acts as low power
    logic [4:0] exp [4] = '{5'h10, 5'h0B, 5'h10, 5'h05};
    enable = 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(PUSC_CMD_USER_CFG, {13'h0000, c[0], 2'(c)});
      chk("low_side_on", 16'(c[0]), 16'(ctrl.low_side_on));
      telem_read = 1'b1;
      cyc(1);
      telem_read = 1'b0;
      chk("standby", 16'(exp[c]), 16'({ctrl.low_power, ctrl.monitor_cont,
          ctrl.monitor_pulsed, ctrl.telemetry_avail, telem_sample}));
    end
    enable = 1'b1;
  endtask : t_standby

  task automatic t_share();
    link_id = 5'h05;
    wr(PUSC_CMD_SHARE_CFG, host.share_word(5'h05, 4'h3, 3'h3, 1'b1));
    chk("member", 16'h0001, 16'(share.member));
    chk("rail_id", 16'h0005, 16'(share.rail_id));
    chk("members_m1", 16'h0002, 16'(share.members_m1));
    chk("position", 16'h0003, 16'(share.position));
    chk("id match", 16'h0000, 16'(share.id_mismatch));
    link_id = 5'h06;
    cyc(2);
    chk("id mismatch", 16'h0001, 16'(share.id_mismatch));
    wr(PUSC_CMD_SHARE_CFG, host.share_word(5'h05, 4'h3, 3'h7, 1'b0));
    chk("standalone", 16'h0000, 16'(share.member));
    chk("link rail_id", 16'h0006, 16'(share.rail_id));
    chk("position max", 16'h0007, 16'(share.position));
  endtask : t_share

  task automatic t_sync();
    wr(PUSC_CMD_USER_CFG, 16'h0820);
    chk("sync_oe on", 16'h0001, 16'(sync_oe));
    chk("sync_o", 16'(int_sw_clk), 16'(sync_o));
    chk("sw_clk internal", 16'(int_sw_clk), 16'(sw_clk));
    cyc(1);
    chk("sync_o next", 16'(int_sw_clk), 16'(sync_o));
    enable = 1'b0;
    cyc(15);
    chk("sync_oe before timeout", 16'h0001, 16'(sync_oe));
    cyc(10);
    chk("sync_oe after timeout", 16'h0000, 16'(sync_oe));
    enable = 1'b1;
    cyc(3);
    chk("sync_oe re-enabled", 16'h0001, 16'(sync_oe));
    wr(PUSC_CMD_USER_CFG, 16'h0020);
    enable = 1'b0;
    cyc(30);
    chk("sync_oe no timeout", 16'h0001, 16'(sync_oe));
    wr(PUSC_CMD_USER_CFG, 16'h0000);
    chk("sync_oe input only", 16'h0000, 16'(sync_oe));
    wr(PUSC_CMD_USER_CFG, 16'h0060);
    chk("use_ext_clk", 16'h0001, 16'(ctrl.use_ext_clk));
    chk("sync_oe ext", 16'h0000, 16'(sync_oe));
    sync_i = 1'b1;
    cyc(5);
    chk("sw_clk high", 16'h0001, 16'(sw_clk));
    sync_i = 1'b0;
    cyc(5);
    chk("sw_clk low", 16'h0000, 16'(sw_clk));
    wr(PUSC_CMD_USER_CFG, 16'h0000);
    sync_i = 1'b1;
    cyc(5);
    chk("auto ext", 16'h0001, 16'(ctrl.use_ext_clk));
    sync_i = 1'b0;
    cyc(300);
    chk("auto internal", 16'h0000, 16'(ctrl.use_ext_clk));
    enable = 1'b1;
  endtask : t_sync

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    enable = 1'b1;
    seq_en = 1'b0;
    fault_rx = 1'b0;
    in_group = 1'b0;
    telem_read = 1'b0;
    int_sw_clk = 1'b0;
    sync_i = 1'b0;
    link_id = 5'h00;
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    cyc(1);
    t_reset();
    t_masks();
    t_loop_cfg();
    t_fault();
    t_standby();
    t_share();
    t_sync();
    end_sim();
  end
endmodule : power_user_and_share_config_test
